// File: logic/abr_pkg.sv
package abr_pkg;
  // ****************************************
  // Address selection
  // ****************************************
  localparam int unsigned ABR_SEL_LSB      = 11;
  localparam int unsigned ABR_SEL_MSB      = 14;
  localparam logic [23:0] ABR_BASE_ADDR    = 24'h900000;
  localparam logic [23:0] ABR_BASE_STEP    = 24'h004000;
  localparam int unsigned ABR_SPAN_BITS    = 14;
  localparam int unsigned ABR_NUM_CH       = 4;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ABR_OFS_CTRL     = 12'h000;
  localparam logic [11:0] ABR_OFS_STATUS   = 12'h004;
  localparam logic [11:0] ABR_OFS_CONFIG   = 12'h008;
  localparam logic [31:0] ABR_CTRL_RESET   = 32'h00000000;
  // Control field positions: pulse/dir enables then serial enables
  localparam int unsigned ABR_CTRL_PD_LSB  = 0;
  localparam int unsigned ABR_CTRL_SE_LSB  = 4;
  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic en_route_ch1;
    logic en_route_ch2;
    logic flt_route_ch1;
    logic flt_route_ch2;
    logic idx_share_ch1;
    logic idx_share_ch2;
  } abr_jumpers_t;
  typedef struct packed {
    logic [ABR_NUM_CH-1:0] oe;
    logic [ABR_NUM_CH-1:0] val;
  } abr_pin_t;
  // ****************************************
  // Shared decode
  // ****************************************
  function automatic logic [23:0] abr_base_of(input logic [3:0] idx);
    abr_base_of = ABR_BASE_ADDR + (ABR_BASE_STEP * {20'h00000, idx});
  endfunction
endpackage

// File: logic/abr_pin_routing.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module abr_pin_routing
  import abr_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire logic [3:0]            address_select_switches_in,
  input  wire abr_jumpers_t          jumpers_in,
  input  wire logic                  piggyback_in,
  input  wire logic [23:0]           host_addr_in,
  output logic                       host_select_out,
  output logic [3:0]                 board_index_out,
  output logic [23:0]                board_base_out,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [ABR_NUM_CH-1:0] pd_pulse_in,
  input  wire logic [ABR_NUM_CH-1:0] amp_enable_in,
  input  wire logic [ABR_NUM_CH-1:0] serial_encoder_enable_out_in,
  input  wire logic [ABR_NUM_CH-1:0] amp_board_fault_in,
  input  wire logic [ABR_NUM_CH-1:0] enc_b_pin_in,
  input  wire logic [ABR_NUM_CH-1:0] enc_a_pin_in,
  input  wire logic [ABR_NUM_CH-1:0] enc_c_pin_in,
  output abr_pin_t                   flag_pin_out,
  output abr_pin_t                   enc_a_pin_out,
  output abr_pin_t                   enc_c_pin_out,
  output logic [ABR_NUM_CH-1:0]      amp_fault_out,
  output logic [ABR_NUM_CH-1:0]      enc_a_rx_out,
  output logic [ABR_NUM_CH-1:0]      enc_c_rx_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0]            sw_m_q, sw_s_q;
  abr_jumpers_t          jp_m_q, jp_s_q;
  logic                  pig_m_q, pig_s_q;
  logic [ABR_NUM_CH-1:0] b_m_q, b_s_q, a_m_q, a_s_q, c_m_q, c_s_q;

  // Two-stage sync of static straps and encoder pins
  always_ff @(posedge sys_clk_in) begin
    sw_m_q  <= address_select_switches_in;
    sw_s_q  <= sw_m_q;
    jp_m_q  <= jumpers_in;
    jp_s_q  <= jp_m_q;
    pig_m_q <= piggyback_in;
    pig_s_q <= pig_m_q;
    b_m_q   <= enc_b_pin_in;
    b_s_q   <= b_m_q;
    a_m_q   <= enc_a_pin_in;
    a_s_q   <= a_m_q;
    c_m_q   <= enc_c_pin_in;
    c_s_q   <= c_m_q;
  end

  // ****************************************
  // Static configuration capture
  // ****************************************
  logic [3:0]   index_q;
  abr_jumpers_t cfg_q;
  logic         pig_q;

  // Latched only while reset holds
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      index_q <= sw_s_q;
      cfg_q   <= jp_s_q;
      pig_q   <= pig_s_q;
    end
  end

  // ****************************************
  // Address window decode
  // ****************************************
  logic [23:0] base_q;
  logic        sel_q;

  // Base from index; select on window match
  always_ff @(posedge sys_clk_in) begin
    base_q <= abr_base_of(index_q);
    sel_q  <= (host_addr_in[23:ABR_SPAN_BITS] == base_q[23:ABR_SPAN_BITS]);
  end
  assign board_index_out = index_q;
  assign board_base_out  = base_q;
  assign host_select_out = sel_q;

  // ****************************************
  // APB register slave
  // ****************************************
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic        ready_q;
  logic        err_q;
  logic        hit;

  assign hit = (paddr == ABR_OFS_CTRL) || (paddr == ABR_OFS_STATUS) || (paddr == ABR_OFS_CONFIG);

  // Control register, cleared by reset
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl_q <= ABR_CTRL_RESET;
    end else if (psel && penable && ready_q && pwrite && paddr == ABR_OFS_CTRL) begin
      ctrl_q <= {24'h000000, pwdata[7:0]};
    end
  end

  // One wait state: ready in second access cycle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (psel && penable && !ready_q) begin
      ready_q <= 1'b1;
      err_q   <= !hit;
      unique case (paddr)
        ABR_OFS_CTRL:   rdata_q <= ctrl_q;
        ABR_OFS_STATUS: rdata_q <= {8'h00, base_q};
        ABR_OFS_CONFIG: rdata_q <= {21'h000000, pig_q, cfg_q.idx_share_ch2, cfg_q.idx_share_ch1,
                                    cfg_q.flt_route_ch2, cfg_q.flt_route_ch1, cfg_q.en_route_ch2,
                                    cfg_q.en_route_ch1, index_q};
        default:        rdata_q <= 32'h00000000;
      endcase
    end else begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end
  end
  assign prdata  = rdata_q;
  assign pready  = ready_q;
  assign pslverr = err_q;

  // ****************************************
  // Pin routing
  // ****************************************
  logic [ABR_NUM_CH-1:0] pd_en, se_en, en_rt, flt_rt, idx_dir;
  abr_pin_t              flag_q, a_q, c_q;
  logic [ABR_NUM_CH-1:0] flt_q, a_rx_q, c_rx_q;

  assign pd_en = ctrl_q[ABR_CTRL_PD_LSB +: ABR_NUM_CH];
  assign se_en = ctrl_q[ABR_CTRL_SE_LSB +: ABR_NUM_CH];
  // Hardware channel 1/3 take first-channel jumpers, 2/4 the second
  assign en_rt   = pig_q ? {cfg_q.en_route_ch2, cfg_q.en_route_ch1, 2'b00}
                         : {2'b00, cfg_q.en_route_ch2, cfg_q.en_route_ch1};
  assign flt_rt  = pig_q ? {cfg_q.flt_route_ch2, cfg_q.flt_route_ch1, 2'b00}
                         : {2'b00, cfg_q.flt_route_ch2, cfg_q.flt_route_ch1};
  // Jumper low is pins 1-2 (share index with serial enable)
  assign idx_dir = pig_q ? {!cfg_q.idx_share_ch2, !cfg_q.idx_share_ch1, 2'b00}
                         : {2'b00, !cfg_q.idx_share_ch2, !cfg_q.idx_share_ch1};

  // Registered pin drivers and receivers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      flag_q <= '0;
      a_q    <= '0;
      c_q    <= '0;
      flt_q  <= '0;
      a_rx_q <= '0;
      c_rx_q <= '0;
    end else begin
      flag_q.oe  <= pd_en;
      flag_q.val <= pd_pulse_in & pd_en;
      a_q.oe     <= en_rt;
      a_q.val    <= amp_enable_in & en_rt;
      a_rx_q     <= a_s_q & ~en_rt;
      c_q.oe     <= se_en & idx_dir;
      c_q.val    <= serial_encoder_enable_out_in & se_en & idx_dir;
      c_rx_q     <= c_s_q & ~(se_en & idx_dir);
      flt_q      <= (flt_rt & b_s_q) | (~flt_rt & amp_board_fault_in);
    end
  end
  assign flag_pin_out  = flag_q;
  assign enc_a_pin_out = a_q;
  assign enc_c_pin_out = c_q;
  assign amp_fault_out = flt_q;
  assign enc_a_rx_out  = a_rx_q;
  assign enc_c_rx_out  = c_rx_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  // First access edge of a transfer
  sequence s_apb_access;
    psel && penable && !ready_q;
  endsequence

  // Completing edge of a control write
  sequence s_ctrl_write;
    psel && penable && ready_q && pwrite && (paddr == ABR_OFS_CTRL);
  endsequence

  // First edge after reset release
  sequence s_reset_left;
    $fell(reset_in);
  endsequence

  // Control register empty when reset ends
  chk_ctrl_reset_clear: assert property (s_reset_left |-> ctrl_q == ABR_CTRL_RESET)
    else $error("control not cleared by reset");

  // Base follows the captured index
  chk_base_from_index: assert property (##1 base_q == ABR_BASE_ADDR + {6'h00, $past(index_q), 14'h0000})
    else $error("base address mismatch");

  // Index frozen outside reset
  chk_index_stable: assert property ($stable(index_q))
    else $error("index changed outside reset");

  // Jumper and board position frozen outside reset
  chk_cfg_stable: assert property ($stable(cfg_q) && $stable(pig_q))
    else $error("jumpers changed outside reset");

  // Flag direction follows the enable
  chk_flag_dir_pd: assert property (!$past(reset_in) |-> flag_q.oe == $past(pd_en))
    else $error("flag direction wrong");

  // Flag line quiet while it is an input
  chk_flag_val_mask: assert property (!pd_en[0] |=> !flag_q.val[0])
    else $error("flag driven while input");

  // Encoder A direction follows the jumpers
  chk_enc_a_route: assert property (!$past(reset_in) |-> a_q.oe == $past(en_rt))
    else $error("encoder A direction wrong");

  // Received encoder A cut while driving, first channel
  chk_enc_a_rx_cut1: assert property (en_rt[0] |=> !a_rx_q[0])
    else $error("encoder A received while output");

  // Received encoder A cut while driving, piggyback second channel
  chk_enc_a_rx_cut4: assert property (en_rt[3] |=> !a_rx_q[3])
    else $error("encoder A received while output");

  // Fault tracks encoder B when routed
  chk_fault_follows_b: assert property (flt_rt[0] && $stable(flt_rt) |=> flt_q[0] == $past(b_s_q[0]))
    else $error("fault not following encoder B");

  // Fault comes from amplifier board by default
  chk_fault_from_amp: assert property (!flt_rt[1] && $stable(flt_rt) |=> flt_q[1] == $past(amp_board_fault_in[1]))
    else $error("fault not from amplifier");

  // Index lines kept as inputs at 2-3
  chk_index_inputs_kept: assert property (!idx_dir[0] |=> !c_q.oe[0])
    else $error("index line driven at 2-3");

  // Index line value quiet while input
  chk_index_val_off: assert property (!c_q.oe[0] |-> !c_q.val[0])
    else $error("index line value while input");

  // Serial enable drives index lines at 1-2
  chk_index_serial_out: assert property (idx_dir[1] && se_en[1] |=> c_q.oe[1])
    else $error("serial enable not routed");

  // Received index cut while driving
  chk_c_rx_cut: assert property (c_q.oe[2] |-> !c_rx_q[2])
    else $error("index received while output");

  // One wait state, one-cycle answer
  chk_apb_one_wait: assert property (s_apb_access |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // Ready never stands two cycles
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");

  // Unmapped offset answers with error
  chk_apb_err_unmapped: assert property (s_apb_access ##0 !hit |=> pslverr)
    else $error("unmapped access not refused");

  // Status read returns the base
  chk_status_read: assert property (s_apb_access ##0 (paddr == ABR_OFS_STATUS) |=> prdata == {8'h00, $past(base_q)})
    else $error("status read wrong");

  // Control write lands at completing edge
  chk_ctrl_write_lands: assert property (s_ctrl_write |=> ctrl_q[7:0] == $past(pwdata[7:0]))
    else $error("control write lost");

  // Window select on matching address
  chk_sel_window: assert property (host_addr_in == base_q && $stable(base_q) |=> host_select_out)
    else $error("window select missing");

endmodule

// File: verif/abr_host_model.sv
`timescale 1ns/1ps
// ****************************
// Host CPU bus master
// ****************************
module abr_host_model (
  input  wire logic        sys_clk_in,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  // Idle bus at time zero; one accessory only, so no index clash
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // One transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(negedge sys_clk_in);
    while (pready !== 1'b1) begin
      @(negedge sys_clk_in);
    end
    r = prdata;
    e = pslverr;
    @(posedge sys_clk_in);
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
// ****************************
// Routing bench
// ****************************
module testbench;
  import abr_pkg::*;
  logic         clk = 1'b0, rst = 1'b1, pig = 1'b0, sel_o, psel, penable, pwrite, pready, pslverr, err;
  logic [3:0]   sw = 4'h0, pd = 4'h0, amp_en = 4'h0, ser_o = 4'h0, amp_flt = 4'h0, mask;
  logic [3:0]   enc_a = 4'h0, enc_b = 4'h0, enc_c = 4'h0, idx_o, fault_o, a_rx, c_rx;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [23:0]  haddr = 24'h000000, base_o, exp_base;
  abr_jumpers_t jmp = '0;
  abr_pin_t     flag_o, enca_o, encc_o;
  int           errors = 0, total_checks = 0;
  // Clock 40 MHz
  always #12.5 clk = ~clk;
  abr_pin_routing uut (.sys_clk_in(clk), .reset_in(rst), .address_select_switches_in(sw), .jumpers_in(jmp),
    .piggyback_in(pig), .host_addr_in(haddr), .host_select_out(sel_o), .board_index_out(idx_o),
    .board_base_out(base_o), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pd_pulse_in(pd),
    .amp_enable_in(amp_en), .serial_encoder_enable_out_in(ser_o), .amp_board_fault_in(amp_flt),
    .enc_b_pin_in(enc_b), .enc_a_pin_in(enc_a), .enc_c_pin_in(enc_c), .flag_pin_out(flag_o),
    .enc_a_pin_out(enca_o), .enc_c_pin_out(encc_o), .amp_fault_out(fault_o), .enc_a_rx_out(a_rx),
    .enc_c_rx_out(c_rx));
  abr_host_model host (.sys_clk_in(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Verdict and end of run
  task print_verdict;
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Value compare
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Reset with new straps, held 20 cycles
  task automatic reset_dut(input logic [3:0] s, input abr_jumpers_t j, input logic p);
    @(posedge clk);
    rst <= 1'b1;
    sw <= s;
    jmp <= j;
    pig <= p;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end
  // Test sequence
  initial begin
    reset_dut(4'h0, '0, 1'b0);
    check_val(idx_o, 0, "index");
    check_val(base_o, 24'h900000, "base");
    host.xfer(1'b0, ABR_OFS_CTRL, 32'h0, rd, err);
    check_val(rd, ABR_CTRL_RESET, "ctrl reset");
    host.xfer(1'b0, ABR_OFS_STATUS, 32'h0, rd, err);
    check_val(rd, 32'h00900000, "status");
    host.xfer(1'b1, ABR_OFS_CTRL, 32'h0000000F, rd, err);
    pd <= 4'hA;
    settle;
    check_val(flag_o.oe, 4'hF, "flag oe");
    check_val(flag_o.val, 4'hA, "flag val");
    reset_dut(4'h0, '0, 1'b0);
    check_val(flag_o.oe, 4'h0, "flag oe reset");
    host.xfer(1'b1, 12'h00C, 32'hFF, rd, err);
    check_val(err, 1'b1, "unmapped err");
    host.xfer(1'b0, ABR_OFS_CTRL, 32'h0, rd, err);
    check_val(rd, 32'h0, "no write");
    for (int i = 0; i < 16; i++) begin
      reset_dut(i[3:0], '0, 1'b0);
      exp_base = 24'h900000 + 24'h004000 * i[23:0];
      check_val(idx_o, i[3:0], "index");
      check_val(base_o, exp_base, "base");
      haddr <= exp_base + 24'h000010;
      settle;
      check_val(sel_o, 1'b1, "select in");
      haddr <= exp_base + 24'h004000;
      settle;
      check_val(sel_o, 1'b0, "select out");
    end
    amp_en <= 4'hF;
    ser_o <= 4'hF;
    enc_a <= 4'hF;
    enc_b <= 4'h5;
    enc_c <= 4'hF;
    amp_flt <= 4'hA;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 2; m++) begin
        reset_dut(4'h0, (m == 1) ? 6'b000011 : 6'b111100, p[0]);
        host.xfer(1'b1, ABR_OFS_CTRL, 32'h000000F0, rd, err);
        settle;
        mask = (m == 1) ? 4'h0 : ((p == 1) ? 4'hC : 4'h3);
        check_val(enca_o.oe, mask, "enc a oe");
        check_val(enca_o.val & enca_o.oe, mask, "enc a val");
        check_val(a_rx, ~mask & 4'hF, "enc a rx");
        check_val(fault_o, (4'h5 & mask) | (4'hA & ~mask), "fault");
        check_val(encc_o.oe, mask, "enc c oe");
        check_val(encc_o.val, mask, "enc c val");
        check_val(c_rx, ~mask & 4'hF, "enc c rx");
        host.xfer(1'b0, ABR_OFS_CONFIG, 32'h0, rd, err);
        check_val(rd, {21'h000000, p[0], (m == 1) ? 6'h30 : 6'h0F, 4'h0}, "config");
      end
    end
    print_verdict;
  end
endmodule
